/* File: hdl/cccx_consts.svh */
// register offsets, field positions and reset values of the execute block
`ifndef CCCX_CONSTS_SVH
`define CCCX_CONSTS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define CCCX_OFS_INSTR      8'h00
`define CCCX_OFS_ACC        8'h04
`define CCCX_OFS_STATUS     8'h08
`define CCCX_OFS_CONFIG     8'h0c
`define CCCX_OFS_FILE_ADDR  8'h10
`define CCCX_OFS_FILE_DATA  8'h14
`define CCCX_OFS_EXEC_COUNT 8'h18

// ************************************************************
// field positions and widths
// ************************************************************
`define CCCX_INSTR_W        11
`define CCCX_STATUS_W       4
`define CCCX_CFG_PSC_WDT    0
`define CCCX_ADDR_W         7
`define CCCX_DATA_W         8

// ************************************************************
// reset values and the decrement step
// ************************************************************
`define CCCX_RST_ACC        8'h00
`define CCCX_RST_STATUS     4'hc
`define CCCX_RST_CONFIG     1'h0
`define CCCX_RST_COUNT      16'h0000
`define CCCX_DEC_ONE        8'h01

`endif

/* File: hdl/cccx_pkg.sv */
// types shared by the execute block and its result unit
package cccx_pkg;

	// ************************************************************
	// operations, in encoding order 0..6
	// ************************************************************
	typedef enum logic [2:0] {
		no_op,
		accumulator_clear_op,
		watchdog_restart_op,
		register_clear_op,
		register_invert_op,
		compare_op,
		register_decrement_op
	} cccx_op_e;

	typedef struct packed {
		logic [6:0] addr;
		logic       dest;
		cccx_op_e   op;
	} cccx_instr_s;

	typedef struct packed {
		logic powerdown_status_n;
		logic timeout_status_n;
		logic carry;
		logic zero;
	} cccx_status_s;

	typedef struct packed {
		logic [7:0] result;
		logic       wr_acc;
		logic       wr_file;
		logic       upd_zero;
		logic       upd_carry;
		logic       zero;
		logic       carry;
		logic       wdt_restart;
	} cccx_alu_s;

endpackage

/* File: hdl/cccx_alu.sv */
// result unit: one instruction in, result and flag updates out
`timescale 1ns/1ps
`include "cccx_consts.svh"

module cccx_alu (
	input  wire cccx_pkg::cccx_instr_s instr,
	input  wire logic [7:0]            acc,
	input  wire logic [7:0]            file_val,
	output cccx_pkg::cccx_alu_s        res
);
	logic [8:0] diff;
	logic [7:0] dec_val;
	logic [7:0] inv_val;

	assign diff    = {1'b0, file_val} - {1'b0, acc};
	assign dec_val = file_val - `CCCX_DEC_ONE;
	assign inv_val = ~file_val;

	always_comb begin
		res = '0;
		case (instr.op)
			cccx_pkg::accumulator_clear_op: begin
				res.wr_acc   = 1'b1;
				res.upd_zero = 1'b1;
				res.zero     = 1'b1;
			end
			cccx_pkg::watchdog_restart_op: begin
				res.wdt_restart = 1'b1;
			end
			cccx_pkg::register_clear_op: begin
				res.wr_file  = 1'b1;
				res.upd_zero = 1'b1;
				res.zero     = 1'b1;
			end
			cccx_pkg::register_invert_op: begin
				res.result   = inv_val;
				res.wr_acc   = ~instr.dest;
				res.wr_file  = instr.dest;
				res.upd_zero = 1'b1;
				res.zero     = (inv_val == 8'h00);
			end
			cccx_pkg::compare_op: begin
				// result dropped, only flags move
				res.upd_zero  = 1'b1;
				res.upd_carry = 1'b1;
				res.zero      = (diff[7:0] == 8'h00);
				res.carry     = ~diff[8];
			end
			cccx_pkg::register_decrement_op: begin
				res.result   = dec_val;
				res.wr_acc   = ~instr.dest;
				res.wr_file  = instr.dest;
				res.upd_zero = 1'b1;
				res.zero     = (dec_val == 8'h00);
			end
			default: begin
				res = '0;
			end
		endcase
	end
endmodule

/* File: hdl/cccx_exec.sv */
// execute block for clear, complement, compare and decrement with apb registers
//
// Contract
// - accumulator clear loads zero into the accumulator and sets the zero flag.
// - watchdog restart resets the watchdog counter to zero.
// - watchdog restart also zeroes the shared prescaler only while it serves the watchdog.
// - watchdog restart sets both the timeout and powerdown status bits to one.
// - register clear writes zero to the addressed file register and sets the zero flag.
// - register invert produces the bitwise inverse of the register and updates zero from it.
// - for invert and decrement, dest 0 writes the accumulator and dest 1 the source register.
// - compare computes register minus accumulator and updates zero and carry from it.
// - compare leaves the accumulator and the register unchanged.
// - decrement subtracts one from the register and updates zero before storing.
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "cccx_consts.svh"

module cccx_exec #(
	parameter int DEPTH = 128
) (
	input  wire  logic        core_clk,
	input  wire  logic        rst,
	input  wire  logic        psel,
	input  wire  logic        penable,
	input  wire  logic        pwrite,
	input  wire  logic [7:0]  paddr,
	input  wire  logic [31:0] pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire  logic        timeout_event,
	input  wire  logic        sleep_event,
	output logic              watchdog_clear,
	output logic              prescaler_clear,
	output logic [7:0]        accumulator,
	output cccx_pkg::cccx_status_s status_out
);

	// ************************************************************
	// state
	// ************************************************************
	logic [7:0]             file_mem [DEPTH];
	logic [7:0]             acc_reg;
	cccx_pkg::cccx_status_s status_reg;
	cccx_pkg::cccx_status_s status_next;
	cccx_pkg::cccx_instr_s  instr_reg;
	logic                   psc_wdt_reg;
	logic [6:0]             file_addr_reg;
	logic [15:0]            count_reg;
	logic [31:0]            prdata_reg;
	logic                   pready_reg;
	logic                   pslverr_reg;
	logic                   wdt_clr_reg;
	logic                   psc_clr_reg;

	// ************************************************************
	// bus decode
	// ************************************************************
	wire logic       setup_ph   = psel & ~penable;
	wire logic       access_ph  = psel & penable & pready_reg;
	wire logic       wr_en      = access_ph & pwrite;
	wire logic       sel_instr  = (paddr == `CCCX_OFS_INSTR);
	wire logic       sel_acc    = (paddr == `CCCX_OFS_ACC);
	wire logic       sel_status = (paddr == `CCCX_OFS_STATUS);
	wire logic       sel_config = (paddr == `CCCX_OFS_CONFIG);
	wire logic       sel_faddr  = (paddr == `CCCX_OFS_FILE_ADDR);
	wire logic       sel_fdata  = (paddr == `CCCX_OFS_FILE_DATA);
	wire logic       sel_count  = (paddr == `CCCX_OFS_EXEC_COUNT);
	wire logic       mapped     = sel_instr | sel_acc | sel_status | sel_config |
	                              sel_faddr | sel_fdata | sel_count;
	wire logic       exec_fire  = wr_en & sel_instr;

	// ************************************************************
	// instruction execution
	// ************************************************************
	// the instruction is taken straight from the write data so it executes
	// on the very edge that completes the bus write
	cccx_pkg::cccx_instr_s new_instr;
	cccx_pkg::cccx_alu_s   alu_res;
	logic [7:0]            file_rd;

	assign new_instr = cccx_pkg::cccx_instr_s'(pwdata[`CCCX_INSTR_W-1:0]);
	assign file_rd   = file_mem[new_instr.addr];

	cccx_alu u_alu (
		.instr    (new_instr),
		.acc      (acc_reg),
		.file_val (file_rd),
		.res      (alu_res)
	);

	wire logic do_wr_acc  = exec_fire & alu_res.wr_acc;
	wire logic do_wr_file = exec_fire & alu_res.wr_file;
	wire logic do_wdt     = exec_fire & alu_res.wdt_restart;
	wire logic sw_wr_file = wr_en & sel_fdata;

	always_comb begin
		status_next = status_reg;
		if (wr_en & sel_status) begin
			status_next = cccx_pkg::cccx_status_s'(pwdata[`CCCX_STATUS_W-1:0]);
		end
		if (timeout_event) begin
			status_next.timeout_status_n = 1'b0;
		end
		if (sleep_event) begin
			status_next.powerdown_status_n = 1'b0;
		end
		// the restart wins over a same-cycle timeout or sleep clear
		if (do_wdt) begin
			status_next.timeout_status_n   = 1'b1;
			status_next.powerdown_status_n = 1'b1;
		end
		if (exec_fire & alu_res.upd_zero) begin
			status_next.zero = alu_res.zero;
		end
		if (exec_fire & alu_res.upd_carry) begin
			status_next.carry = alu_res.carry;
		end
	end

	// ************************************************************
	// read mux
	// ************************************************************
	logic [31:0] rd_val;

	always_comb begin
		rd_val = 32'h0000_0000;
		if (sel_instr) begin
			rd_val = {21'h000000, instr_reg};
		end
		if (sel_acc) begin
			rd_val = {24'h000000, acc_reg};
		end
		if (sel_status) begin
			rd_val = {28'h0000000, status_reg};
		end
		if (sel_config) begin
			rd_val = {31'h00000000, psc_wdt_reg};
		end
		if (sel_faddr) begin
			rd_val = {25'h0000000, file_addr_reg};
		end
		if (sel_fdata) begin
			rd_val = {24'h000000, file_mem[file_addr_reg]};
		end
		if (sel_count) begin
			rd_val = {16'h0000, count_reg};
		end
	end

	// ************************************************************
	// apb handshake
	// ************************************************************
	// one wait-free answer: ready rises in the access phase after each setup
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else if (setup_ph) begin
			pready_reg  <= 1'b1;
			pslverr_reg <= ~mapped;
			prdata_reg  <= pwrite ? 32'h0000_0000 : rd_val;
		end else begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end
	end

	// ************************************************************
	// accumulator and status
	// ************************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			acc_reg <= `CCCX_RST_ACC;
		end else if (do_wr_acc) begin
			acc_reg <= alu_res.result;
		end else if (wr_en & sel_acc) begin
			acc_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			status_reg <= cccx_pkg::cccx_status_s'(`CCCX_RST_STATUS);
		end else begin
			status_reg <= status_next;
		end
	end

	// ************************************************************
	// configuration and bookkeeping
	// ************************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			psc_wdt_reg   <= `CCCX_RST_CONFIG;
			file_addr_reg <= 7'h00;
		end else begin
			if (wr_en & sel_config) begin
				psc_wdt_reg <= pwdata[`CCCX_CFG_PSC_WDT];
			end
			if (wr_en & sel_faddr) begin
				file_addr_reg <= pwdata[`CCCX_ADDR_W-1:0];
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			instr_reg <= '0;
			count_reg <= `CCCX_RST_COUNT;
		end else if (exec_fire) begin
			instr_reg <= new_instr;
			count_reg <= count_reg + 16'h0001;
		end
	end

	// ************************************************************
	// file register array
	// ************************************************************
	// no reset on the array: it models plain ram, software must initialise it
	always_ff @(posedge core_clk) begin
		if (do_wr_file) begin
			file_mem[new_instr.addr] <= alu_res.result;
		end else if (sw_wr_file) begin
			file_mem[file_addr_reg] <= pwdata[7:0];
		end
	end

	// ************************************************************
	// watchdog and prescaler strobes
	// ************************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wdt_clr_reg <= 1'b0;
			psc_clr_reg <= 1'b0;
		end else begin
			wdt_clr_reg <= do_wdt;
			psc_clr_reg <= do_wdt & psc_wdt_reg;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign prdata          = prdata_reg;
	assign pready          = pready_reg;
	assign pslverr         = pslverr_reg;
	assign watchdog_clear  = wdt_clr_reg;
	assign prescaler_clear = psc_clr_reg;
	assign accumulator     = acc_reg;
	assign status_out      = status_reg;

endmodule

/* File: tb/cccx_exec_sva.sv */
// assertion checker on the execute block ports
`timescale 1ns/1ps
module cccx_exec_chk (
	input wire logic                   core_clk,
	input wire logic                   rst,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [7:0]             paddr,
	input wire logic [31:0]            pwdata,
	input wire logic                   pready,
	input wire logic                   watchdog_clear,
	input wire logic                   prescaler_clear,
	input wire logic [7:0]             accumulator,
	input wire cccx_pkg::cccx_status_s status_out
);
	// ************************************************************
	// bus timing and instruction effects
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_setup;
		psel && !penable;
	endsequence
	// the executing edge: an accepted write of the instruction word
	sequence s_exec(logic [2:0] op);
		psel && penable && pwrite && pready && paddr == 8'h00 && pwdata[2:0] == op;
	endsequence
	a_ready_next: assert property (s_setup |=> pready)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_acc_clear: assert property (s_exec(3'h1) |=> accumulator == 8'h00 && status_out.zero)
		else $error("accumulator clear wrong");
	a_wdt_restart: assert property (s_exec(3'h2) |=> watchdog_clear ##1 !watchdog_clear)
		else $error("watchdog pulse wrong");
	a_psc_only_wdt: assert property (prescaler_clear |-> watchdog_clear)
		else $error("prescaler clear without restart");
	a_restart_flags: assert property (s_exec(3'h2) |=>
		status_out.timeout_status_n && status_out.powerdown_status_n)
		else $error("restart status bits wrong");
	a_clear_zero: assert property (s_exec(3'h3) |=> status_out.zero)
		else $error("register clear zero flag wrong");
	a_cmp_keeps: assert property (s_exec(3'h5) |=> accumulator == $past(accumulator))
		else $error("compare changed accumulator");
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the execute block
`timescale 1ns/1ps
`include "cccx_consts.svh"
module tb_top;
	// ************************************************************
	// signals, tasks and sequence
	// ************************************************************
	logic                   core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
	logic                   pwrite = 1'b0, timeout_event = 1'b0, sleep_event = 1'b0;
	logic                   pready, pslverr, watchdog_clear, prescaler_clear, e;
	logic [7:0]             paddr = 8'h00, accumulator;
	logic [31:0]            pwdata = 32'h0, prdata, q;
	cccx_pkg::cccx_status_s status_out;
	int                     n_errors = 0, comparisons = 0, seed = 3281;
	int                     n_wdt = 0, n_psc = 0, n_instr = 0;
	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		n_wdt += int'(watchdog_clear === 1'b1);
		n_psc += int'(prescaler_clear === 1'b1);
	end
	cccx_exec #(.DEPTH(128)) DUT (.core_clk(core_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timeout_event(timeout_event),
		.sleep_event(sleep_event), .watchdog_clear(watchdog_clear),
		.prescaler_clear(prescaler_clear), .accumulator(accumulator), .status_out(status_out));
	task automatic cmp(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, x);
		end
	endtask
	// one idle cycle after each transfer keeps every drive to one change per edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(a, 1'b0, 32'h0);
		cmp(q, x);
	endtask
	function automatic logic [19:0] model(input logic [2:0] op, input logic dst,
		input logic [7:0] a, input logic [7:0] r, input logic [3:0] s);
		logic [7:0] v;
		logic [8:0] df;
		df = {1'b0, r} - {1'b0, a};
		v = (op == 3'h4) ? ~r : r - 8'h01;
		case (op)
			3'h1: begin a = 8'h00; s[0] = 1'b1; end
			3'h2: s[3:2] = 2'b11;
			3'h3: begin r = 8'h00; s[0] = 1'b1; end
			3'h4, 3'h6: begin
				s[0] = (v == 8'h00);
				if (dst) r = v; else a = v;
			end
			3'h5: begin s[0] = (df[7:0] == 8'h00); s[1] = ~df[8]; end
			default: ;
		endcase
		return {a, r, s};
	endfunction
	task automatic run(input logic [2:0] op, input logic dst, input logic [6:0] ad,
		input logic [7:0] a, input logic [7:0] r, input logic [3:0] s, input logic cfg);
		logic [19:0] x;
		int w0, p0;
		x = model(op, dst, a, r, s);
		wr(`CCCX_OFS_FILE_ADDR, {25'h0, ad});
		wr(`CCCX_OFS_FILE_DATA, {24'h0, r});
		wr(`CCCX_OFS_ACC, {24'h0, a});
		wr(`CCCX_OFS_STATUS, {28'h0, s});
		wr(`CCCX_OFS_CONFIG, {31'h0, cfg});
		w0 = n_wdt;
		p0 = n_psc;
		wr(`CCCX_OFS_INSTR, {21'h0, ad, dst, op});
		n_instr++;
		rd(`CCCX_OFS_ACC, {24'h0, x[19:12]});
		rd(`CCCX_OFS_FILE_DATA, {24'h0, x[11:4]});
		rd(`CCCX_OFS_STATUS, {28'h0, x[3:0]});
		cmp(32'(n_wdt - w0), 32'(op == 3'h2));
		cmp(32'(n_psc - p0), 32'(op == 3'h2 && cfg));
	endtask
	task automatic stop_test;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ample margin over roughly 2000 cycles of traffic
	initial begin
		#(25 * 20000);
		n_errors++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd(`CCCX_OFS_STATUS, 32'hc);
		rd(`CCCX_OFS_ACC, 32'h0);
		rd(`CCCX_OFS_CONFIG, 32'h0);
		apb(8'h1c, 1'b0, 32'h0);
		cmp({31'h0, e}, 32'h1);
		$display("test reset done");
		run(3'h5, 1'b0, 7'h00, 8'h12, 8'h34, 4'hc, 1'b0);
		run(3'h5, 1'b1, 7'h7f, 8'h34, 8'h34, 4'h0, 1'b0);
		run(3'h5, 1'b0, 7'h01, 8'h35, 8'h34, 4'h3, 1'b0);
		run(3'h6, 1'b1, 7'h7f, 8'h10, 8'h00, 4'h1, 1'b0);
		run(3'h6, 1'b0, 7'h02, 8'h10, 8'h01, 4'h0, 1'b0);
		run(3'h4, 1'b1, 7'h03, 8'h00, 8'ha6, 4'h1, 1'b0);
		run(3'h4, 1'b0, 7'h04, 8'h55, 8'hff, 4'h0, 1'b0);
		run(3'h2, 1'b0, 7'h05, 8'h55, 8'h66, 4'h0, 1'b1);
		run(3'h2, 1'b0, 7'h05, 8'h55, 8'h66, 4'h3, 1'b0);
		run(3'h1, 1'b0, 7'h06, 8'h55, 8'h77, 4'h0, 1'b0);
		run(3'h3, 1'b1, 7'h7f, 8'h11, 8'h55, 4'h2, 1'b0);
		run(3'h7, 1'b1, 7'h08, 8'h11, 8'h22, 4'h5, 1'b1);
		$display("test corners done");
		repeat (60) run(3'(1 + {$random(seed)} % 6), 1'($random(seed)), 7'($random(seed)),
			8'($random(seed)), 8'($random(seed)), 4'($random(seed)), 1'($random(seed)));
		$display("test random done");
		wr(`CCCX_OFS_STATUS, 32'hc);
		@(posedge core_clk);
		timeout_event <= 1'b1;
		sleep_event <= 1'b1;
		@(posedge core_clk);
		timeout_event <= 1'b0;
		sleep_event <= 1'b0;
		rd(`CCCX_OFS_STATUS, 32'h0);
		rd(`CCCX_OFS_EXEC_COUNT, 32'(n_instr));
		$display("test events done");
		stop_test();
	end
endmodule
bind cccx_exec cccx_exec_chk u_chk (.core_clk(core_clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.watchdog_clear(watchdog_clear), .prescaler_clear(prescaler_clear),
	.accumulator(accumulator), .status_out(status_out));
